// >>> hdl/sdcs_pkg.sv
/*
 * Constants and types shared by the conversion and calibration sequencer.
 * Assumes a single 200 MHz system clock and a host-side register port.
 */
package sdcs_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_COMM   = 3'h0;
    localparam logic [2:0] ADDR_SETUP  = 3'h1;
    localparam logic [2:0] ADDR_CLOCK  = 3'h2;
    localparam logic [2:0] ADDR_DATA   = 3'h3;
    localparam logic [2:0] ADDR_OFFSET = 3'h4;
    localparam logic [2:0] ADDR_GAIN   = 3'h5;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int COMM_CH_BIT    = 0;
    localparam int COMM_PD_BIT    = 1;
    localparam int COMM_DATA_READY_N_BIT  = 7;
    localparam int SETUP_HOLD_BIT = 0;
    localparam int SETUP_MD_LO    = 6;
    localparam int CLK_FS_LO      = 0;
    localparam int CLK_FAM_BIT    = 2;
    localparam int CLK_HALVE_BIT  = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_FSEL  = 2'h1;
    localparam logic       RST_FAM   = 1'b1;
    localparam logic       RST_HALVE = 1'b0;
    localparam logic       RST_HOLD  = 1'b1;

    // ------------------------------------------------------------
    // timing in input-clock ticks and output periods
    // ------------------------------------------------------------
    localparam logic [10:0] PIPE_TICKS   = 11'h7D0;  // 2000
    localparam logic [10:0] GAP_TICKS    = 11'h1F4;  // 500
    localparam int          MOD_SHIFT    = 7;        // 128 ticks per cycle
    localparam logic [3:0]  PER_NORMAL   = 4'h3;
    localparam logic [3:0]  PER_SELF_CAL = 4'h6;
    localparam logic [3:0]  PER_SYS_CAL  = 4'h3;
    localparam logic [3:0]  PER_CAL_CONV = 4'h3;
    localparam logic [3:0]  PER_SYS_CONV = 4'h1;

    // ------------------------------------------------------------
    // calibration modes and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SDCS_MD_NORMAL = 2'h0,
        SDCS_MD_SELF   = 2'h1,
        SDCS_MD_ZERO   = 2'h2,
        SDCS_MD_FULL   = 2'h3
    } sdcs_mode_t;

    typedef enum logic [4:0] {
        SDCS_HOLD   = 5'h01,
        SDCS_CAL    = 5'h02,
        SDCS_SETTLE = 5'h04,
        SDCS_PIPE   = 5'h08,
        SDCS_RUN    = 5'h10
    } sdcs_state_t;

    // decimation rate per rate family and filter select
    function automatic logic [8:0] sdcs_dec(input logic fam,
                                            input logic [1:0] fsel);
        logic [8:0] r;
        r = 9'h000;
        unique case ({fam, fsel})
            3'h0: r = 9'h187;  // 391
            3'h1: r = 9'h139;  // 313
            3'h2: r = 9'h04E;  // 78
            3'h3: r = 9'h027;  // 39
            3'h4: r = 9'h180;  // 384
            3'h5: r = 9'h140;  // 320
            3'h6: r = 9'h04D;  // 77
            3'h7: r = 9'h026;  // 38
        endcase
        return r;
    endfunction : sdcs_dec

endpackage : sdcs_pkg

// >>> hdl/sdcs_sequencer.sv
/*
 * Conversion and calibration sequencer of a two-channel sigma-delta
 * converter: rate selection, hold input, data-ready flag, calibration.
 * Assumes the host keeps its own ordering obligations and that the
 * converter input clock arrives asynchronously on clock_input_pin_i.
 */
`timescale 1ns/1ps

module sdcs_sequencer (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // converter clock pins
    input  wire logic        clock_input_pin_i,
    output logic             clock_output_pin_o,
    // register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [23:0] rdata_o,
    // status pins
    output logic             data_ready_n_o,
    output logic      [1:0]  cal_mode_o
);

    typedef struct packed {
        logic                 sync1;
        logic                 sync2;
        logic                 clk_prev;
        logic                 halve_tog;
        logic                 clock_output_pin;
        logic                 comm_ch;
        logic                 powerdown_bit;
        logic                 configured;
        logic                 hold;
        logic [1:0]           cal_mode;
        logic                 fam;
        logic                 halve;
        logic [1:0]           fsel;
        logic [1:0][23:0]     off;
        logic [1:0][23:0]     gain;
        logic [23:0]          act_off;
        logic [15:0]          data;
        logic [15:0]          conv_cnt;
        logic                 data_ready_n_n;
        logic [10:0]          gap_cnt;
        logic [15:0]          tick_cnt;
        logic [3:0]           per_cnt;
        logic [3:0]           per_tgt;
        logic                 pipe;
        logic [1:0]           run_mode;
        sdcs_pkg::sdcs_state_t state;
        logic [23:0]          rdata;
    } sdcs_st_t;

    sdcs_st_t r;
    sdcs_st_t next_r;

    // ------------------------------------------------------------
    // derived strobes
    // ------------------------------------------------------------
    logic        clk_edge;
    logic        tick;
    logic [15:0] per_len;
    logic        per_end;
    logic        rd_data;
    logic        setup_wr;
    logic        run_ok;
    logic        deliver;

    // edge of the synchronised input clock
    assign clk_edge = r.sync2 & ~r.clk_prev;
    // optional halving of the input clock
    assign tick = clk_edge & (~r.halve | r.halve_tog);
    assign per_len = {sdcs_pkg::sdcs_dec(r.fam, r.fsel),
                      {sdcs_pkg::MOD_SHIFT{1'b0}}};
    assign per_end = tick && (r.tick_cnt == per_len - 16'h0001);
    assign rd_data = rd_i && (addr_i == sdcs_pkg::ADDR_DATA);
    assign setup_wr = wr_i && (addr_i == sdcs_pkg::ADDR_SETUP);
    // conversions only when set up and released
    assign run_ok = r.configured & ~r.hold & ~r.powerdown_bit;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        deliver = 1'b0;
        // synchroniser; first stage read by second only
        next_r.sync1 = clock_input_pin_i;
        next_r.sync2 = r.sync1;
        next_r.clk_prev = r.sync2;
        next_r.clock_output_pin = r.sync2;
        if (clk_edge)
        begin
            next_r.halve_tog = ~r.halve_tog;
        end

        // register writes
        if (wr_i)
        begin
            unique case (addr_i)
                sdcs_pkg::ADDR_COMM:
                begin
                    // command write ends the wait state
                    next_r.comm_ch = wdata_i[sdcs_pkg::COMM_CH_BIT];
                    next_r.powerdown_bit = wdata_i[sdcs_pkg::COMM_PD_BIT];
                    next_r.configured = 1'b1;
                end
                sdcs_pkg::ADDR_SETUP:
                begin
                    next_r.hold = wdata_i[sdcs_pkg::SETUP_HOLD_BIT];
                    next_r.cal_mode = wdata_i[sdcs_pkg::SETUP_MD_LO +: 2];
                end
                sdcs_pkg::ADDR_CLOCK:
                begin
                    next_r.fsel = wdata_i[sdcs_pkg::CLK_FS_LO +: 2];
                    next_r.fam = wdata_i[sdcs_pkg::CLK_FAM_BIT];
                    next_r.halve = wdata_i[sdcs_pkg::CLK_HALVE_BIT];
                end
                // stored only; offset used at next acquisition, gain only read back
                sdcs_pkg::ADDR_OFFSET: next_r.off[r.comm_ch] = wdata_i;
                sdcs_pkg::ADDR_GAIN:   next_r.gain[r.comm_ch] = wdata_i;
                default: ;
            endcase
        end

        // register reads, data one cycle later
        next_r.rdata = 24'h000000;
        if (rd_i)
        begin
            unique case (addr_i)
                sdcs_pkg::ADDR_COMM:
                    next_r.rdata = {16'h0000, r.data_ready_n_n, 5'h00,
                                    r.powerdown_bit, r.comm_ch};
                sdcs_pkg::ADDR_SETUP:
                    next_r.rdata = {16'h0000, r.cal_mode, 5'h00, r.hold};
                sdcs_pkg::ADDR_CLOCK:
                    next_r.rdata = {20'h00000, r.halve, r.fam, r.fsel};
                sdcs_pkg::ADDR_DATA:   next_r.rdata = {8'h00, r.data};
                sdcs_pkg::ADDR_OFFSET: next_r.rdata = r.off[r.comm_ch];
                sdcs_pkg::ADDR_GAIN:   next_r.rdata = r.gain[r.comm_ch];
                default:               next_r.rdata = 24'h000000;
            endcase
        end

        // read releases the flag; a new result below wins
        if (rd_data)
        begin
            next_r.data_ready_n_n = 1'b1;
        end

        // period timer, restarted whenever the sequencer is idle
        if (tick)
        begin
            next_r.tick_cnt = per_end ? 16'h0000 : r.tick_cnt + 16'h0001;
        end

        if (r.gap_cnt != 11'h000 && tick)
        begin
            next_r.gap_cnt = r.gap_cnt - 11'h001;
            if (r.gap_cnt == 11'h001)
            begin
                next_r.data_ready_n_n = 1'b0;
            end
        end

        unique case (r.state)
            sdcs_pkg::SDCS_HOLD:
            begin
                next_r.tick_cnt = 16'h0000;
                next_r.per_cnt = 4'h0;
                if (run_ok)
                begin
                    next_r.data_ready_n_n = 1'b1;
                    next_r.gap_cnt = 11'h000;
                    next_r.act_off = r.off[r.comm_ch];
                    next_r.run_mode = r.cal_mode;
                    next_r.pipe = 1'b0;
                    unique case (r.cal_mode)
                        // three periods to the first result
                        sdcs_pkg::SDCS_MD_NORMAL:
                        begin
                            next_r.per_tgt = sdcs_pkg::PER_NORMAL;
                            next_r.state = sdcs_pkg::SDCS_SETTLE;
                        end
                        sdcs_pkg::SDCS_MD_SELF:
                        begin
                            next_r.per_tgt = sdcs_pkg::PER_SELF_CAL;
                            next_r.state = sdcs_pkg::SDCS_CAL;
                        end
                        default:
                        begin
                            next_r.per_tgt = sdcs_pkg::PER_SYS_CAL;
                            next_r.state = sdcs_pkg::SDCS_CAL;
                        end
                    endcase
                end
            end
            sdcs_pkg::SDCS_CAL:
            begin
                if (per_end)
                begin
                    next_r.per_cnt = r.per_cnt + 4'h1;
                    if (r.per_cnt + 4'h1 == r.per_tgt)
                    begin
                        next_r.cal_mode = sdcs_pkg::SDCS_MD_NORMAL;
                        if (r.run_mode != sdcs_pkg::SDCS_MD_FULL)
                        begin
                            next_r.off[r.comm_ch] = {8'h00, r.conv_cnt};
                        end
                        if (r.run_mode != sdcs_pkg::SDCS_MD_ZERO)
                        begin
                            next_r.gain[r.comm_ch] = {8'h00, ~r.conv_cnt};
                        end
                        next_r.per_cnt = 4'h0;
                        next_r.pipe = 1'b1;
                        next_r.per_tgt =
                            (r.run_mode == sdcs_pkg::SDCS_MD_SELF)
                            ? sdcs_pkg::PER_CAL_CONV
                            : sdcs_pkg::PER_SYS_CONV;
                        next_r.state = sdcs_pkg::SDCS_SETTLE;
                    end
                end
            end
            sdcs_pkg::SDCS_SETTLE:
            begin
                if (per_end)
                begin
                    next_r.per_cnt = r.per_cnt + 4'h1;
                    if (r.per_cnt + 4'h1 == r.per_tgt)
                    begin
                        next_r.per_cnt = 4'h0;
                        if (r.pipe)
                        begin
                            next_r.gap_cnt = 11'h000;
                            next_r.per_cnt = 4'h0;
                            next_r.tick_cnt = 16'h0000;
                            next_r.state = sdcs_pkg::SDCS_PIPE;
                        end
                        else
                        begin
                            deliver = 1'b1;
                            next_r.state = sdcs_pkg::SDCS_RUN;
                        end
                    end
                end
            end
            sdcs_pkg::SDCS_PIPE:
            begin
                // tick_cnt reused as the pipeline counter
                if (tick)
                begin
                    next_r.tick_cnt = r.tick_cnt + 16'h0001;
                    if (r.tick_cnt == {5'h00, sdcs_pkg::PIPE_TICKS}
                                      - 16'h0001)
                    begin
                        next_r.tick_cnt = 16'h0000;
                        deliver = 1'b1;
                        next_r.state = sdcs_pkg::SDCS_RUN;
                    end
                end
            end
            sdcs_pkg::SDCS_RUN:
            begin
                // free running, one result per period
                if (per_end)
                begin
                    next_r.act_off = r.off[r.comm_ch];
                    deliver = 1'b1;
                end
            end
            default: next_r.state = sdcs_pkg::SDCS_HOLD;
        endcase

        // new result: flag low, or blanked first if still unread
        if (deliver)
        begin
            next_r.conv_cnt = r.conv_cnt + 16'h0001;
            next_r.data = r.conv_cnt + r.act_off[15:0];
            if (!r.data_ready_n_n && !rd_data)
            begin
                next_r.data_ready_n_n = 1'b1;
                next_r.gap_cnt = sdcs_pkg::GAP_TICKS;
            end
            else
            begin
                next_r.data_ready_n_n = 1'b0;
            end
        end

        // hold stops work, pending flag untouched
        // a calibration command while running restarts the sequence
        if (r.state != sdcs_pkg::SDCS_HOLD &&
            (!run_ok || (setup_wr && wdata_i[sdcs_pkg::SETUP_MD_LO +: 2]
                                     != 2'h0)))
        begin
            next_r.state = sdcs_pkg::SDCS_HOLD;
            next_r.gap_cnt = 11'h000;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // defaults on reset, bus ignored meanwhile
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            r <= '0;
            r.fsel <= sdcs_pkg::RST_FSEL;
            r.fam <= sdcs_pkg::RST_FAM;
            r.halve <= sdcs_pkg::RST_HALVE;
            r.hold <= sdcs_pkg::RST_HOLD;
            r.data_ready_n_n <= 1'b1;
            r.state <= sdcs_pkg::SDCS_HOLD;
            // clock path keeps running through reset
            r.sync1 <= next_r.sync1;
            r.sync2 <= next_r.sync2;
            r.clk_prev <= next_r.clk_prev;
            r.clock_output_pin <= next_r.clock_output_pin;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign clock_output_pin_o = r.clock_output_pin;
    assign data_ready_n_o = r.data_ready_n_n;
    assign cal_mode_o = r.cal_mode;
    assign rdata_o = r.rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_flag;
        @(posedge clk_i) !rstn_i |=> r.data_ready_n_n && !r.configured;
    endproperty
    a_reset_flag: assert property (p_reset_flag)
        else $error("flag not high after reset");

    property p_read_release;
        @(posedge clk_i) disable iff (!rstn_i)
        rd_data && !deliver && !(tick && r.gap_cnt == 11'h001)
        |=> r.data_ready_n_n;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("data read did not release flag");

    property p_hold_keeps;
        @(posedge clk_i) disable iff (!rstn_i)
        r.hold && r.state == sdcs_pkg::SDCS_HOLD && !r.data_ready_n_n
        && !rd_data |=> !r.data_ready_n_n;
    endproperty
    a_hold_keeps: assert property (p_hold_keeps)
        else $error("pending flag lost during hold");

    property p_hold_stops;
        @(posedge clk_i) disable iff (!rstn_i)
        r.hold |=> r.state == sdcs_pkg::SDCS_HOLD;
    endproperty
    a_hold_stops: assert property (p_hold_stops)
        else $error("sequencer ran while held");

    property p_cal_clears;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(r.pipe)
        |-> r.cal_mode == 2'h0 && r.state == sdcs_pkg::SDCS_SETTLE;
    endproperty
    a_cal_clears: assert property (p_cal_clears)
        else $error("mode not cleared at calibration end");

    property p_period_bound;
        @(posedge clk_i) disable iff (!rstn_i)
        r.state != sdcs_pkg::SDCS_PIPE |-> r.tick_cnt < per_len;
    endproperty
    a_period_bound: assert property (p_period_bound)
        else $error("period counter beyond period length");

    property p_gap_high;
        @(posedge clk_i) disable iff (!rstn_i)
        r.gap_cnt > 11'h001 && !r.hold |=> r.data_ready_n_n;
    endproperty
    a_gap_high: assert property (p_gap_high)
        else $error("flag fell before blanking ended");

    property p_data_on_deliver;
        @(posedge clk_i) disable iff (!rstn_i)
        !deliver |=> $stable(r.data);
    endproperty
    a_data_on_deliver: assert property (p_data_on_deliver)
        else $error("data changed without a result");

    property p_no_run_unset;
        @(posedge clk_i) disable iff (!rstn_i)
        !r.configured |-> r.state == sdcs_pkg::SDCS_HOLD;
    endproperty
    a_no_run_unset: assert property (p_no_run_unset)
        else $error("conversion before command write");

    property p_clk_follows;
        @(posedge clk_i) r.sync2 |=> r.clock_output_pin;
    endproperty
    a_clk_follows: assert property (p_clk_follows)
        else $error("clock output interrupted");

endmodule : sdcs_sequencer

// >>> verif/sdcs_osc_model.sv
/*
 * Free-running converter input clock standing in for the external
 * oscillator on the far side of clock_input_pin.
 * Assumes a 1 ns time unit and a 200 MHz system clock.
 */
`timescale 1ns/1ps
module sdcs_osc_model (
    // oscillator output
    output logic clk_o
);
    // offset phase so edges never land on system clock edges
    initial
    begin
        clk_o = 1'b0;
        #1.3;
        forever #5.0 clk_o = ~clk_o;
    end
endmodule : sdcs_osc_model

// >>> verif/sigma_delta_conversion_sequencer_test.sv
/*
 * Self-checking bench: reset, free run, blanking, hold, read release
 * and a zero-scale system calibration at decimation 38.
 * Assumes one converter tick every second system clock.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
        $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
        err_total++; \
    end
module sigma_delta_conversion_sequencer_test;
    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    localparam int P   = 128 * 38 * 2;  // system cycles per period
    localparam int TOL = 12;            // sync and tick alignment
    logic        clk_i     = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        osc;
    logic        clk_out;
    logic [2:0]  addr_i    = 3'h0;
    logic [23:0] wdata_i   = 24'h000000;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [23:0] rdata_o;
    logic        data_ready_n_o;
    logic [1:0]  cal_mode_o;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          tog       = 0;
    logic [23:0] d;
    int          n;
    int          m;

    always #2.5 clk_i = ~clk_i;
    // clock output must keep toggling while reset is held
    always @(clk_out) if (!rstn_i) tog++;

    sdcs_osc_model i_sdcs_osc_model (.clk_o(osc));
    sdcs_sequencer i_sdcs_sequencer (
        .clk_i(clk_i), .rstn_i(rstn_i), .clock_input_pin_i(osc),
        .clock_output_pin_o(clk_out), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .data_ready_n_o(data_ready_n_o), .cal_mode_o(cal_mode_o));

    // ------------------------------------------------------------
    // bus cycles and helpers
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [2:0] a, input logic [23:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [23:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        v = rdata_o;
    endtask : rd_reg

    // sel 0 flag low, 1 flag high, 2 mode normal; bounded wait
    task automatic wait_for(input int sel, input int lim, output int c);
        c = 0;
        do
        begin
            @(negedge clk_i);
            c++;
        end
        while (c < lim && !(sel == 0 ? data_ready_n_o === 1'b0 :
               sel == 1 ? data_ready_n_o === 1'b1 : cal_mode_o === 2'h0));
    endtask : wait_for

    function automatic logic near(input int v, input int e, input int t);
        return (v >= e - t) && (v <= e + t);
    endfunction : near

    task tally_and_finish;
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        @(negedge clk_i);
        `CHK("data_ready_n_rst", 1'b1, data_ready_n_o)
        `CHK("clock_output_pin_run", 1'b1, tog > 4)
        rd_reg(sdcs_pkg::ADDR_CLOCK, d);
        `CHK("clock_dflt", 4'h5, d[3:0])
        rd_reg(3'h6, d);
        `CHK("unmapped", 24'h000000, d)
        rd_reg(sdcs_pkg::ADDR_COMM, d);
        `CHK("comm_bit", 1'b1, d[sdcs_pkg::COMM_DATA_READY_N_BIT])
    endtask : t_reset

    task automatic t_free_run;
        wr_reg(sdcs_pkg::ADDR_COMM, 24'h000000);
        wr_reg(sdcs_pkg::ADDR_CLOCK, 24'h000007);
        wr_reg(sdcs_pkg::ADDR_SETUP, 24'h000000);
        wait_for(0, 3 * P + 100, n);
        `CHK("first", 1'b1, near(n, 3 * P, TOL))
        rd_reg(sdcs_pkg::ADDR_COMM, d);
        `CHK("comm_rdy", 1'b0, d[sdcs_pkg::COMM_DATA_READY_N_BIT])
        // leave the result unread so the next one blanks the flag
        wait_for(1, P + 100, n);
        wait_for(0, 2000, n);
        `CHK("blank", 1'b1, near(n, 1000, 4))
    endtask : t_free_run

    task automatic t_hold_read;
        wr_reg(sdcs_pkg::ADDR_SETUP, 24'h000001);
        repeat (40) @(negedge clk_i);
        `CHK("hold_low", 1'b0, data_ready_n_o)
        rd_reg(sdcs_pkg::ADDR_DATA, d);
        `CHK("rd_clear", 1'b1, data_ready_n_o)
    endtask : t_hold_read

    task automatic t_sys_cal;
        wr_reg(sdcs_pkg::ADDR_SETUP, 24'h000080);
        repeat (3) @(negedge clk_i);
        `CHK("mode_zero", 2'h2, cal_mode_o)
        wait_for(2, 3 * P + 100, n);
        `CHK("mode_done", 1'b1, near(n + 3, 3 * P, TOL))
        wait_for(0, P + 4100, m);
        `CHK("cal_rdy", 1'b1, near(n + m + 3, 4 * P + 4000, TOL))
        // zero-scale touches only the offset of the chosen channel
        rd_reg(sdcs_pkg::ADDR_GAIN, d);
        `CHK("gain_kept", 24'h000000, d)
        rd_reg(sdcs_pkg::ADDR_OFFSET, d);
        `CHK("off_cal", 1'b1, d != 24'h000000)
    endtask : t_sys_cal

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_i);
        // must be ignored while reset is low
        wr_reg(sdcs_pkg::ADDR_CLOCK, 24'h000000);
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset;
        t_free_run;
        t_hold_read;
        t_sys_cal;
        tally_and_finish;
    end

    // run needs about 83k cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            err_total++;
            tally_and_finish;
        end
    end
endmodule : sigma_delta_conversion_sequencer_test
